// file: dv/net_ctl_model.sv
// Network controller model: issues one object access at a time.
// Assumes the answer arrives one cycle after the request edge.
`timescale 1ns/1ps

module net_ctl_model (
  input wire logic mclk, // System clock
  output logic net_req, // Access pulse
  output logic net_wr, // Write flag
  output param_access_pkg::obj_sel_t net_obj, // Object selected
  output logic [15:0] net_wdata, // Write value
  input wire logic net_ack, // Answer pulse
  input wire logic [15:0] net_rdata, // Read value
  input wire logic [7:0] net_err_code // Refusal code
);
  import param_access_pkg::*;

  initial begin
    net_req = 1'b0;
    net_wr = 1'b0;
    net_obj = OBJ_ADDR;
    net_wdata = 16'h0000;
  end

  // One pulse, answer taken at the edge that brings it
  task automatic acc(input logic wr, input obj_sel_t obj,
                     input logic [15:0] d, output logic [15:0] rd,
                     output logic [7:0] ec);
    @(posedge mclk);
    #1;
    net_req = 1'b1;
    net_wr = wr;
    net_obj = obj;
    net_wdata = d;
    @(posedge mclk);
    #1;
    net_req = 1'b0;
    // Released data shows no stale value
    net_wdata = ~d;
    rd = net_rdata;
    ec = net_ack ? net_err_code : 8'hff;
  endtask : acc
endmodule : net_ctl_model

// file: dv/tb_top.sv
// Self-checking bench for the indirect parameter access unit.
// Assumes the controller model drives the object port; loopback is wired here.
`timescale 1ns/1ps

module tb_top;
  import param_access_pkg::*;
  logic mclk = 1'b0;
  logic rst_n, net_req, net_wr, net_ack, name_wr, write_inhibit;
  logic bus_undervoltage_fault, nv_clear, lb_rx, lb_tx, lb_fault;
  obj_sel_t net_obj;
  logic [15:0] net_wdata, net_rdata;
  logic [7:0] net_err_code, name_char;
  logic [4:0] name_idx;
  logic [21:0] instance_id;
  logic [159:0] device_name;
  logic test_mode, test_pass, test_comm_error, nv_busy, mstp_master;
  logic [16:0] baud_div;
  logic [8:0] services_mask;
  logic [6:0] object_types_mask;
  int errors = 0;
  int total_checks = 0;

  assign lb_rx = lb_tx ^ lb_fault;
  always #10 mclk = ~mclk;

  net_ctl_model i_ctl (.mclk(mclk), .net_req(net_req), .net_wr(net_wr),
    .net_obj(net_obj), .net_wdata(net_wdata), .net_ack(net_ack),
    .net_rdata(net_rdata), .net_err_code(net_err_code));

  indirect_parameter_access i_dut (.mclk(mclk), .rst_n(rst_n),
    .net_req(net_req), .net_wr(net_wr), .net_obj(net_obj),
    .net_wdata(net_wdata), .net_ack(net_ack), .net_rdata(net_rdata),
    .net_err_code(net_err_code), .name_wr(name_wr), .name_idx(name_idx),
    .name_char(name_char), .write_inhibit(write_inhibit),
    .bus_undervoltage_fault(bus_undervoltage_fault), .nv_clear(nv_clear),
    .lb_rx(lb_rx), .lb_tx(lb_tx), .instance_id(instance_id),
    .device_name(device_name), .test_mode(test_mode),
    .test_pass(test_pass), .test_comm_error(test_comm_error),
    .nv_busy(nv_busy), .baud_div(baud_div), .mstp_master(mstp_master),
    .services_mask(services_mask), .object_types_mask(object_types_mask));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // Address object then value object write
  task automatic rw(input logic [15:0] a, input logic [15:0] v,
                    input logic [7:0] ee);
    logic [15:0] r;
    logic [7:0] e;
    i_ctl.acc(1'b1, OBJ_ADDR, a, r, e);
    chk(e, 8'h00);
    i_ctl.acc(1'b1, OBJ_VALUE, v, r, e);
    chk(e, ee);
  endtask : rw

  task automatic rd(input logic [15:0] a, input logic [15:0] ev,
                    input logic [7:0] ee);
    logic [15:0] r;
    logic [7:0] e;
    i_ctl.acc(1'b1, OBJ_ADDR, a, r, e);
    i_ctl.acc(1'b0, OBJ_VALUE, 16'h0000, r, e);
    chk(e, ee);
    if (ee == 8'h00) begin
      chk(r, ev);
    end
  endtask : rd

  task automatic cmd(input obj_sel_t o, input logic [7:0] ee);
    logic [15:0] r;
    logic [7:0] e;
    i_ctl.acc(1'b1, o, 16'h0001, r, e);
    chk(e, ee);
  endtask : cmd

  task automatic power_cycle();
    @(posedge mclk);
    #1;
    rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    @(posedge mclk);
    #1;
  endtask : power_cycle

  task automatic t_stage();
    logic [15:0] r;
    logic [7:0] e;
    rw(16'h0105, 16'h0003, 8'h00);
    rw(16'h0103, 16'h0002, 8'h00);
    rd(16'h0105, 16'h0000, 8'h00);
    cmd(OBJ_ACCEPT, 8'h00);
    rd(16'h0105, 16'h0003, 8'h00);
    rd(16'h0103, 16'h0002, 8'h00);
    i_ctl.acc(1'b0, OBJ_VALUE, 16'h0000, r, e);
    chk(r, 16'h0002);
    i_ctl.acc(1'b0, OBJ_ACCEPT, 16'h0000, r, e);
    chk({e, r}, 24'h000000);
    i_ctl.acc(1'b0, OBJ_SAVE, 16'h0000, r, e);
    chk({e, r}, 24'h000000);
    chk(baud_div, 17'd5208);
    $display("test stage done");
  endtask : t_stage

  task automatic t_regcmd();
    rw(16'h0105, 16'h0004, 8'h00);
    rw(16'h0910, 16'h0000, 8'h00);
    rd(16'h0105, 16'h0004, 8'h00);
    rw(16'h0910, 16'h0001, 8'h25);
    rd(16'h0910, 16'h0000, 8'h1b);
    rd(16'h0900, 16'h0000, 8'h1b);
    rd(16'h0120, 16'h0000, 8'h1b);
    $display("test regcmd done");
  endtask : t_regcmd

  task automatic t_refuse();
    rw(16'h0120, 16'h0001, 8'h28);
    rw(16'h0100, 16'h0040, 8'h25);
    rw(16'h0105, 16'h0009, 8'h25);
    write_inhibit = 1'b1;
    rw(16'h0105, 16'h0001, 8'h28);
    cmd(OBJ_ACCEPT, 8'h28);
    write_inhibit = 1'b0;
    bus_undervoltage_fault = 1'b1;
    rw(16'h0105, 16'h0001, 8'h28);
    bus_undervoltage_fault = 1'b0;
    $display("test refuse done");
  endtask : t_refuse

  task automatic t_save();
    int n;
    rw(16'h0100, 16'h003f, 8'h00);
    rw(16'h0101, 16'hffff, 8'h00);
    rw(16'h0104, 16'h0043, 8'h00);
    rw(16'h0103, 16'h0000, 8'h00);
    rw(16'h0105, 16'h0008, 8'h00);
    name_wr = 1'b1;
    @(posedge mclk);
    #1;
    name_wr = 1'b0;
    cmd(OBJ_SAVE, 8'h00);
    chk(nv_busy, 1'b1);
    rw(16'h0105, 16'h0001, 8'h03);
    cmd(OBJ_ACCEPT, 8'h03);
    chk(instance_id, 22'h000000);
    chk(device_name[7:0], 8'h20);
    n = 0;
    while (nv_busy === 1'b1 && n < 1100) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(nv_busy, 1'b0);
    power_cycle();
    chk(instance_id, 22'h3fffff);
    chk(device_name[7:0], 8'h41);
    rd(16'h0105, 16'h0008, 8'h00);
    chk(baud_div, 17'd434);
    chk(mstp_master, 1'b1);
    chk({services_mask, object_types_mask}, 16'hffff);
    $display("test save done");
  endtask : t_save

  task automatic t_loop();
    chk(test_mode, 1'b1);
    repeat (12) @(posedge mclk);
    #1;
    chk({test_pass, test_comm_error}, 2'b10);
    lb_fault = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    lb_fault = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(test_comm_error, 1'b1);
    chk(test_pass, 1'b0);
    $display("test loop done");
  endtask : t_loop

  task automatic t_direct();
    rw(16'h0102, 16'h0000, 8'h00);
    cmd(OBJ_ACCEPT, 8'h00);
    rw(16'h0105, 16'h0005, 8'h00);
    rd(16'h0105, 16'h0005, 8'h00);
    chk(baud_div, 17'd1302);
    $display("test direct done");
  endtask : t_direct

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    rst_n = 1'b0;
    nv_clear = 1'b1;
    name_wr = 1'b0;
    name_idx = 5'h00;
    name_char = 8'h41;
    write_inhibit = 1'b0;
    bus_undervoltage_fault = 1'b0;
    lb_fault = 1'b0;
    repeat (20) @(posedge mclk);
    #1;
    nv_clear = 1'b0;
    rst_n = 1'b1;
    t_stage();
    t_regcmd();
    t_refuse();
    t_save();
    t_loop();
    t_direct();
    report_and_stop();
  end

  // Whole run needs about 1150 cycles
  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    report_and_stop();
  end
endmodule : tb_top

// file: include/param_access_cfg.svh
// Constants for the indirect parameter access unit: offsets, fields,
// reset values, error codes and timing counts.
// Assumes a 50 MHz mclk and a 16-entry parameter table.
`ifndef PARAM_ACCESS_CFG_SVH
`define PARAM_ACCESS_CFG_SVH

`define NPARAM 16
`define NAME_LEN 20
`define REG_BASE 16'h0100
`define ENTER_SAVE_REG 16'h0900
`define ACCEPT_RAM_REG 16'h0910

`define IDX_ID_UPPER 4'h0
`define IDX_ID_LOWER 4'h1
`define IDX_COMMIT_SEL 4'h2
`define IDX_PROTOCOL 4'h3
`define IDX_IN6_FUNC 4'h4
`define IDX_BAUD 4'h5

`define ID_UPPER_MAX 16'h003f
`define COMMIT_SEL_MAX 16'h0001
`define PROTOCOL_MAX 16'h0003
`define BAUD_SEL_MAX 16'h0008
`define SELFTEST_FUNC 16'h0043
`define SELFTEST_PROTOCOL 16'h0000
`define COMMIT_SEL_RST 16'h0001
`define PARAM_RST 16'h0000
`define NAME_CHAR_RST 8'h20

`define ERR_NONE 8'h00
`define ERR_BUSY 8'h03
`define ERR_READ_DENIED 8'h1b
`define ERR_RANGE 8'h25
`define ERR_WRITE_DENIED 8'h28

`define MCLK_HZ 50000000
`define MCLK_MHZ 50
`define NV_SAVE_NS 20000
`define NV_SAVE_CYC ((`NV_SAVE_NS * `MCLK_MHZ) / 1000)
`define LB_GOOD_CNT 4'h8

`define BAUD_R0 1200
`define BAUD_R1 2400
`define BAUD_R2 4800
`define BAUD_R3 9600
`define BAUD_R4 19200
`define BAUD_R5 38400
`define BAUD_R6 57600
`define BAUD_R7 76800
`define BAUD_R8 115200

`define SERVICES_MASK 9'h1ff
`define OBJ_TYPES_MASK 7'h7f

`endif

// file: include/param_access_pkg.sv
// Types shared by the parameter access unit and its helpers.
// Assumes param_access_cfg.svh on the include path.
`include "param_access_cfg.svh"

package param_access_pkg;
  typedef logic [15:0] word_t;
  typedef word_t param_img_t [`NPARAM];
  typedef logic [7:0] char_t;
  typedef char_t name_t [`NAME_LEN];

  typedef enum logic [3:0] {
    OBJ_ADDR = 4'b0001,
    OBJ_VALUE = 4'b0010,
    OBJ_ACCEPT = 4'b0100,
    OBJ_SAVE = 4'b1000
  } obj_sel_t;

  typedef enum logic [1:0] {
    NV_IDLE = 2'b01,
    NV_WRITE = 2'b10
  } nv_state_t;
endpackage : param_access_pkg

// file: rtl/indirect_parameter_access.sv
// Indirect parameter access unit: address/value objects, staged writes,
// accept and save commits, refusal codes, identity and self-test mode.
// Assumes the network stack presents one decoded object access per cycle.
`timescale 1ns/1ps
`include "param_access_cfg.svh"

module indirect_parameter_access (
  input wire logic mclk, // System clock, 50 MHz
  input wire logic rst_n, // Sync reset (power cycle), active low
  input wire logic net_req, // Object access pulse
  input wire logic net_wr, // 1 write, 0 read
  input param_access_pkg::obj_sel_t net_obj, // Object selected
  input wire logic [15:0] net_wdata, // Write value
  output logic net_ack, // Answer pulse
  output logic [15:0] net_rdata, // Read value
  output logic [7:0] net_err_code, // 0 or refusal code
  input wire logic name_wr, // Device name character write
  input wire logic [4:0] name_idx, // Name character index
  input wire logic [7:0] name_char, // Name character
  input wire logic write_inhibit, // Writing disabled, e.g. tuning
  input wire logic bus_undervoltage_fault, // DC bus undervoltage
  input wire logic nv_clear, // Load factory defaults into store
  input wire logic lb_rx, // Loopback receive
  output logic lb_tx, // Loopback transmit
  output logic [21:0] instance_id, // Active instance identifier
  output logic [159:0] device_name, // Active name, char 0 low
  output logic test_mode, // Comm self-test active
  output logic test_pass, // Self-test pass indication
  output logic test_comm_error, // Self-test fault indication
  output logic nv_busy, // Saving to non-volatile memory
  output logic [16:0] baud_div, // Clocks per bit, selected rate
  output logic mstp_master, // Runs as MS/TP master
  output logic [8:0] services_mask, // Served services
  output logic [6:0] object_types_mask // Supported object types
);
  import param_access_pkg::*;

  function automatic logic [16:0] baud_cycles(input word_t sel);
    unique case (sel[3:0])
      4'h0: baud_cycles = 17'(`MCLK_HZ / `BAUD_R0);
      4'h1: baud_cycles = 17'(`MCLK_HZ / `BAUD_R1);
      4'h2: baud_cycles = 17'(`MCLK_HZ / `BAUD_R2);
      4'h3: baud_cycles = 17'(`MCLK_HZ / `BAUD_R3);
      4'h4: baud_cycles = 17'(`MCLK_HZ / `BAUD_R4);
      4'h5: baud_cycles = 17'(`MCLK_HZ / `BAUD_R5);
      4'h6: baud_cycles = 17'(`MCLK_HZ / `BAUD_R6);
      4'h7: baud_cycles = 17'(`MCLK_HZ / `BAUD_R7);
      default: baud_cycles = 17'(`MCLK_HZ / `BAUD_R8);
    endcase
  endfunction : baud_cycles

  function automatic logic in_range(input logic [3:0] idx,
                                    input word_t v);
    unique case (idx)
      `IDX_ID_UPPER: in_range = (v <= `ID_UPPER_MAX);
      `IDX_COMMIT_SEL: in_range = (v <= `COMMIT_SEL_MAX);
      `IDX_PROTOCOL: in_range = (v <= `PROTOCOL_MAX);
      `IDX_BAUD: in_range = (v <= `BAUD_SEL_MAX);
      default: in_range = 1'b1;
    endcase
  endfunction : in_range

  word_t addr_r;
  param_img_t work_r;
  param_img_t pend_r;
  param_img_t merged;
  param_img_t stored_img;
  name_t stored_name;
  logic [`NPARAM-1:0] pend_v_r;
  logic boot_r;
  logic ack_r;
  word_t rdata_r;
  logic [7:0] err_r;
  logic [16:0] baud_r;

  // Address decode of the register held in the address object
  wire [15:0] rel = addr_r - `REG_BASE;
  wire is_param = (rel < 16'(`NPARAM));
  wire [3:0] idx = rel[3:0];
  wire is_save_reg = (addr_r == `ENTER_SAVE_REG);
  wire is_accept_reg = (addr_r == `ACCEPT_RAM_REG);
  wire is_writable = is_param || is_save_reg || is_accept_reg;

  // Request classes
  wire wr_addr = net_req && net_wr && (net_obj == OBJ_ADDR);
  wire wr_val = net_req && net_wr && (net_obj == OBJ_VALUE);
  wire rd_val = net_req && !net_wr && (net_obj == OBJ_VALUE);
  wire wr_acc_on = net_req && net_wr && (net_obj == OBJ_ACCEPT)
                   && net_wdata[0];
  wire wr_sav_on = net_req && net_wr && (net_obj == OBJ_SAVE)
                   && net_wdata[0];
  wire wr_cmd_obj = wr_acc_on || wr_sav_on;
  wire lockout = write_inhibit || bus_undervoltage_fault;
  wire val_ok = is_param ? in_range(idx, net_wdata)
                         : (net_wdata == 16'h0000);

  // Busy beats denial, denial beats range
  wire [7:0] wr_err = nv_busy ? `ERR_BUSY :
                      (!is_writable || lockout) ? `ERR_WRITE_DENIED :
                      !val_ok ? `ERR_RANGE :
                      `ERR_NONE;
  wire [7:0] cmd_err = nv_busy ? `ERR_BUSY :
                       lockout ? `ERR_WRITE_DENIED :
                       `ERR_NONE;
  wire wr_good = wr_val && (wr_err == `ERR_NONE);
  wire cmd_good = wr_cmd_obj && (cmd_err == `ERR_NONE);
  wire need_commit = (work_r[`IDX_COMMIT_SEL] != 16'h0000);
  wire stage = wr_good && is_param && need_commit;
  wire direct = wr_good && is_param && !need_commit;
  wire commit_ram = (wr_good && is_accept_reg) ||
                    (cmd_good && wr_acc_on);
  wire commit_save = (wr_good && is_save_reg) ||
                     (cmd_good && wr_sav_on);
  wire commit_any = commit_ram || commit_save;

  // Working image with all pending values applied
  always_comb begin
    for (int i = 0; i < `NPARAM; i++) begin
      merged[i] = pend_v_r[i] ? pend_r[i] : work_r[i];
    end
  end

  wire [7:0] ans_err = wr_val ? wr_err :
                       wr_cmd_obj ? cmd_err :
                       (rd_val && !is_param) ? `ERR_READ_DENIED :
                       `ERR_NONE;
  wire [15:0] ans_data = (net_obj == OBJ_ADDR) ? addr_r :
                         (net_obj == OBJ_VALUE && is_param) ? work_r[idx] :
                         16'h0000;

  nv_param_store u_nv (
    .mclk(mclk),
    .rst_n(rst_n),
    .nv_clear(nv_clear),
    .save_req(commit_save),
    .save_img(merged),
    .name_wr(name_wr),
    .name_idx(name_idx),
    .name_char(name_char),
    .stored_img(stored_img),
    .stored_name(stored_name),
    .busy(nv_busy)
  );

  loopback_tester u_lb (
    .mclk(mclk),
    .rst_n(rst_n),
    .enable(test_mode),
    .lb_rx(lb_rx),
    .lb_tx(lb_tx),
    .pass(test_pass),
    .comm_error(test_comm_error)
  );

  // Answer path, one cycle after each request
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      rdata_r <= 16'h0000;
      err_r <= `ERR_NONE;
      addr_r <= 16'h0000;
    end else begin
      ack_r <= net_req;
      if (net_req) begin
        rdata_r <= net_wr ? 16'h0000 : ans_data;
        err_r <= ans_err;
      end
      if (wr_addr) begin
        addr_r <= net_wdata;
      end
    end
  end

  // Working memory reloads from the saved image at power-up
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      work_r <= stored_img;
      pend_v_r <= '0;
    end else if (commit_any) begin
      work_r <= merged;
      pend_v_r <= '0;
    end else begin
      if (stage) begin
        pend_r[idx] <= net_wdata;
        pend_v_r[idx] <= 1'b1;
      end
      if (direct) begin
        work_r[idx] <= net_wdata;
      end
    end
  end

  // Identity and test mode are caught once, just after power-up
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      boot_r <= 1'b1;
      instance_id <= 22'h000000;
      device_name <= '0;
      test_mode <= 1'b0;
    end else if (boot_r) begin
      boot_r <= 1'b0;
      instance_id <= {work_r[`IDX_ID_UPPER][5:0],
                      work_r[`IDX_ID_LOWER]};
      for (int k = 0; k < `NAME_LEN; k++) begin
        device_name[k*8 +: 8] <= stored_name[k];
      end
      test_mode <= (work_r[`IDX_IN6_FUNC] == `SELFTEST_FUNC) &&
                   (work_r[`IDX_PROTOCOL] == `SELFTEST_PROTOCOL);
    end
  end

  // Rate follows the working value one cycle later, so an accepted change applies without a power cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      baud_r <= 17'(`MCLK_HZ / `BAUD_R0);
    end else begin
      baud_r <= baud_cycles(work_r[`IDX_BAUD]);
    end
  end

  assign net_ack = ack_r;
  assign net_rdata = rdata_r;
  assign net_err_code = err_r;
  assign baud_div = baud_r;
  assign mstp_master = 1'b1;
  assign services_mask = `SERVICES_MASK;
  assign object_types_mask = `OBJ_TYPES_MASK;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_stage_req;
    wr_val && is_param && !nv_busy && !lockout && need_commit &&
    in_range(idx, net_wdata);
  endsequence

  sequence s_save_start;
    commit_save ##1 nv_busy;
  endsequence

  sequence s_lb_slip;
    test_mode && !test_comm_error && (lb_rx != lb_tx);
  endsequence

  // Checks look one cycle after the request edge, where the answer stands.
  // Reset masks them, so a power cycle restarts every sequence.
  addr_keep_a: assert property (wr_addr |=> addr_r == $past(net_wdata)
    ##1 (addr_r == $past(addr_r) || $past(wr_addr)))
    else $error("address object lost its value");
  ack_once_a: assert property (net_req |=> net_ack)
    else $error("request without answer");
  busy_err_a: assert property (wr_val && nv_busy |=>
    net_err_code == 8'h03)
    else $error("write during save not refused busy");
  rd_deny_a: assert property (rd_val && !is_param |=>
    net_err_code == 8'h1b && net_rdata == 16'h0000)
    else $error("bad register read not refused");
  range_err_a: assert property (wr_val && !nv_busy && !lockout &&
    is_param && !in_range(idx, net_wdata) |=> net_err_code == 8'h25)
    else $error("out-of-range write not refused");
  uv_deny_a: assert property (wr_val && !nv_busy &&
    bus_undervoltage_fault |=> net_err_code == 8'h28)
    else $error("undervoltage write not refused");
  stage_hold_a: assert property (s_stage_req |=>
    pend_v_r[$past(idx)] && work_r[$past(idx)] == $past(work_r[idx]))
    else $error("staged write not pending");
  commit_all_a: assert property (commit_ram |=> pend_v_r == '0
    ##1 !nv_busy || $past(commit_save))
    else $error("accept left values pending");
  save_busy_a: assert property (commit_save && !nv_busy |->
    s_save_start ##1 nv_busy[*8])
    else $error("save did not hold busy");
  oneshot_rd_a: assert property (net_req && !net_wr &&
    net_obj == OBJ_ACCEPT |=> net_rdata == 16'h0000 &&
    net_err_code == 8'h00)
    else $error("command object read not off");
  id_fixed_a: assert property (!boot_r |=> $stable(instance_id)
    && $stable(test_mode))
    else $error("identity changed without power cycle");

  // Reads, refusals, direct writes, the device name and the self-test flags
  val_read_a: assert property (rd_val && is_param |=>
    net_rdata == $past(work_r[idx]) && net_err_code == 8'h00)
    else $error("value object read wrong");
  bad_reg_a: assert property (wr_val && !nv_busy && !is_writable |=>
    net_err_code == 8'h28)
    else $error("invalid register write not refused");
  cmd_busy_a: assert property (wr_cmd_obj && nv_busy |=>
    net_err_code == 8'h03)
    else $error("command during save not refused busy");
  direct_wr_a: assert property (direct |=>
    work_r[$past(idx)] == $past(net_wdata))
    else $error("direct write did not land");
  save_rd_a: assert property (net_req && !net_wr &&
    net_obj == OBJ_SAVE |=> net_rdata == 16'h0000 &&
    net_err_code == 8'h00)
    else $error("save object read refused");
  name_fixed_a: assert property (!boot_r |=> $stable(device_name))
    else $error("name changed without power cycle");
  fault_seen_a: assert property (s_lb_slip |=> test_comm_error)
    else $error("loopback fault not flagged");
  err_sticky_a: assert property (test_comm_error |=> test_comm_error)
    else $error("loopback fault flag dropped");
endmodule : indirect_parameter_access

// file: rtl/loopback_tester.sv
// Serial loopback self-test: drives a pseudo-random bit stream and
// checks it back the same cycle through external transmit-receive wiring.
`timescale 1ns/1ps
`include "param_access_cfg.svh"

module loopback_tester (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Sync reset, active low
  input wire logic enable, // Test mode active
  input wire logic lb_rx, // Looped-back receive bit
  output logic lb_tx, // Transmit bit
  output logic pass, // Loopback healthy
  output logic comm_error // Fault seen, sticky
);
  logic [7:0] lfsr_r;
  logic [3:0] good_r;
  logic err_r;
  logic tx_r;
  wire fb = lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3];
  wire mismatch = enable && (lb_rx != tx_r);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lfsr_r <= 8'h01;
      tx_r <= 1'b0;
      good_r <= 4'h0;
      err_r <= 1'b0;
    end else if (enable) begin
      lfsr_r <= {lfsr_r[6:0], fb};
      tx_r <= lfsr_r[7];
      if (mismatch) begin
        err_r <= 1'b1;
      end else if (good_r != `LB_GOOD_CNT) begin
        good_r <= good_r + 4'h1;
      end
    end
  end

  assign lb_tx = tx_r;
  assign comm_error = err_r;
  assign pass = enable && !err_r && (good_r == `LB_GOOD_CNT);
endmodule : loopback_tester

// file: rtl/nv_param_store.sv
// Non-volatile image of the parameter table and the device name.
// Contents survive rst_n (a power cycle); only nv_clear loads defaults.
`timescale 1ns/1ps
`include "param_access_cfg.svh"

module nv_param_store (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Sync reset, active low
  input wire logic nv_clear, // Load factory defaults
  input wire logic save_req, // Store image pulse
  input param_access_pkg::param_img_t save_img, // Image to store
  input wire logic name_wr, // Name character write
  input wire logic [4:0] name_idx, // Character index
  input wire logic [7:0] name_char, // Character value
  output param_access_pkg::param_img_t stored_img, // Saved image
  output param_access_pkg::name_t stored_name, // Saved name
  output logic busy // Save in progress
);
  import param_access_pkg::*;

  nv_state_t state_r;
  logic [10:0] cnt_r;
  wire cnt_done = (cnt_r == 11'h001);

  // Data array is deliberately not reset
  always_ff @(posedge mclk) begin
    if (nv_clear) begin
      for (int i = 0; i < `NPARAM; i++) begin
        stored_img[i] <= (i == int'(`IDX_COMMIT_SEL)) ?
                         `COMMIT_SEL_RST : `PARAM_RST;
      end
      for (int j = 0; j < `NAME_LEN; j++) begin
        stored_name[j] <= `NAME_CHAR_RST;
      end
    end else begin
      if (save_req && state_r == NV_IDLE) begin
        stored_img <= save_img;
      end
      if (name_wr && name_idx < 5'(`NAME_LEN)) begin
        stored_name[name_idx] <= name_char;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r <= NV_IDLE;
      cnt_r <= 11'h000;
    end else begin
      unique case (state_r)
        NV_IDLE: begin
          if (save_req) begin
            state_r <= NV_WRITE;
            cnt_r <= 11'(`NV_SAVE_CYC);
          end
        end
        NV_WRITE: begin
          cnt_r <= cnt_r - 11'h001;
          if (cnt_done) begin
            state_r <= NV_IDLE;
          end
        end
      endcase
    end
  end

  assign busy = (state_r == NV_WRITE);
endmodule : nv_param_store
